//--- smg_sleep_ctrl.sv
// Sleep mode sequencer, clock gating and system clock divider
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
// Operation
// - Divider switching glitch free, no faster step
// - New rate after old plus one-two new
// - Divider counter runs on undivided clock
// - Sleep only with arm bit and halt
// - Select codes map to five modes
// - Interrupt wake holds core four cycles
// - Sleep leaves registers and memory intact
// - Reset during sleep restarts from vector
// - Control resets zero, upper bits zero
// - Idle stops only core and program clocks
// - Idle wakes on external or internal interrupts
// - Idle or noise mode starts conversion
// - Noise mode stops io, core, program clocks
// - Noise mode wake sources restricted
// - Power-down stops oscillator and clocks
// - Power-down wake sources restricted
// - Power-down wake waits for clock start-up
// - Power-save keeps timer two, masked wake
// - Standby keeps oscillator, wakes in six
module smg_sleep_ctrl
  import smg_pkg::*;
#(
  parameter int STARTUP_CYC = 6
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Core and peripherals
  input  wire logic        halt_i,
  input  wire logic        reset_wake_i,
  input  wire logic        adc_enable_i,
  input  wire logic        irq_enable_i,
  input  wire logic [1:0]  timer_two_irq_mask_i,
  input  wire smg_wake_s   wake_i,
  // Clock control
  output smg_clk_s         clk_en_o,
  output logic             cpu_hold_o,
  output logic             adc_start_o,
  output logic             restart_o,
  output logic             sys_tick_o
);

  // ****************************************************************
  // Synchronisers for pin wake sources
  // ****************************************************************
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  always_ff @(posedge clk_i) begin
    pin_meta <= {wake_i.line_zero_level, wake_i.line_zero_edge,
                 wake_i.pin_change};
    pin_sync <= pin_meta;
  end
  wire logic lvl0 = pin_sync[2];
  wire logic edg0 = pin_sync[1];
  wire logic pchg = pin_sync[0];

  // ****************************************************************
  // Registers and bus decode
  // ****************************************************************
  logic [7:0] sleep_control;
  logic [3:0] clock_divide_select;
  smg_state_e state;
  logic [2:0] mode;

  wire logic       bus_req = cyc_i & stb_i & ~ack_o;
  // Write lands at the edge where the master sees ack
  wire logic       wr_lo   = cyc_i & stb_i & ack_o & we_i & sel_i[0];
  wire logic       hit_sc  = adr_i == ADR_SLEEP_CTRL;
  wire logic       hit_div = adr_i == ADR_CLK_DIV;
  wire logic       hit_st  = adr_i == ADR_STATUS;
  wire logic       sleep_arm = sleep_control[SC_ARM_BIT];
  wire logic [2:0] sleep_select =
    sleep_control[SC_SEL_HI:SC_SEL_LO];
  // Reserved divider codes are refused, old value kept
  wire logic       div_ok = dat_i[3:0] <= DIV_MAX_SEL;

  // Unmapped reads answer zero; writes there are dropped
  wire logic [31:0] rd_mux =
    hit_sc  ? {24'h0, sleep_control} :
    hit_div ? {28'h0, clock_divide_select} :
    hit_st  ? {24'h0, 2'h0, 3'(state), mode} : 32'h0;

  // Registered ack; one cycle, then dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o         <= 1'b0;
      dat_o         <= 32'h0;
      sleep_control <= SC_RESET;
    end else begin
      ack_o <= bus_req;
      dat_o <= rd_mux;
      if (wr_lo && hit_sc)
        sleep_control <= dat_i[7:0] & SC_WR_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      clock_divide_select <= DIV_RESET;
    else if (wr_lo && hit_div && div_ok)
      clock_divide_select <= dat_i[3:0];
  end

  // ****************************************************************
  // System clock divider
  // ****************************************************************
  // Terminal count for a power of two factor
  function automatic logic [7:0] div_limit(input logic [3:0] s);
    logic [8:0] f;
    f = 9'h1 << s;
    return 8'(f - 9'h1);
  endfunction

  // Free counter on the undivided clock; software never sees it.
  // The new factor is loaded only at the end of the current old
  // period, so no short pulse and no intermediate faster rate.
  logic [7:0] div_cnt;
  logic [3:0] div_act;
  wire logic  div_wrap = div_cnt >= div_limit(div_act);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt    <= 8'h0;
      div_act    <= DIV_RESET;
      sys_tick_o <= 1'b0;
    end else begin
      sys_tick_o <= div_wrap;
      if (div_wrap) begin
        div_cnt <= 8'h0;
        div_act <= clock_divide_select;
      end else begin
        div_cnt <= div_cnt + 8'h1;
      end
    end
  end

  // ****************************************************************
  // Wake qualification per mode
  // ****************************************************************
  wire logic t2_wake = irq_enable_i &
    ((wake_i.t2_ovf & timer_two_irq_mask_i[0]) |
     (wake_i.t2_cmp & timer_two_irq_mask_i[1]));
  wire logic async_wake = lvl0 | pchg | wake_i.serial_start;
  wire logic quiet_wake = wake_i.store_ready | wake_i.adc_done;
  wire logic idle_wake  = edg0 | wake_i.other_io;

  // Every source comes in as an argument, so the continuous
  // assignment that calls this sees each change of a source.
  function automatic logic wake_ok(input logic [2:0] m, input logic aw,
                                   input logic t2, input logic qt,
                                   input logic il);
    unique case (m)
      SEL_IDLE:  wake_ok = aw | t2 | qt | il;
      SEL_NOISE: wake_ok = aw | t2 | qt;
      SEL_PSAVE: wake_ok = aw | t2;
      default:   wake_ok = aw;
    endcase
  endfunction

  wire logic sel_legal = (sleep_select <= SEL_PSAVE) |
                         (sleep_select == SEL_STANDBY);
  wire logic go_sleep  = halt_i & sleep_arm & sel_legal;
  wire logic woken     = wake_ok(mode, async_wake, t2_wake,
                                 quiet_wake, idle_wake);
  wire logic long_up   = (mode == SEL_PDOWN) | (mode == SEL_PSAVE);

  // Start-up length: oscillator restart or standby fast wake
  wire logic [15:0] up_len = long_up ? 16'(STARTUP_CYC) :
    (mode == SEL_STANDBY) ? 16'(STANDBY_WAKE_CYC) : 16'h0;

  // ****************************************************************
  // Sleep sequencer
  // ****************************************************************
  // Halt without arm leaves the state alone; the core goes on.
  // Nothing here touches the register file or static memory.
  logic [15:0] cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= SMG_ACTIVE;
      mode      <= SEL_IDLE;
      cnt       <= 16'h0;
      restart_o <= 1'b0;
    end else begin
      restart_o <= 1'b0;
      unique case (state)
        SMG_ACTIVE: if (go_sleep) begin
          state <= SMG_ASLEEP;
          mode  <= sleep_select;
        end
        SMG_ASLEEP: if (reset_wake_i) begin
          state     <= SMG_ACTIVE;
          restart_o <= 1'b1;
        end else if (woken && up_len == 16'h0) begin
          state <= SMG_HOLD;
          cnt   <= 16'(HOLD_CYC - 1);
        end else if (woken) begin
          state <= SMG_STARTUP;
          cnt   <= up_len - 16'h1;
        end
        SMG_STARTUP: if (cnt == 16'h0) begin
          state <= SMG_HOLD;
          cnt   <= 16'(HOLD_CYC - 1);
        end else begin
          cnt <= cnt - 16'h1;
        end
        SMG_HOLD: if (cnt == 16'h0) begin
          state <= SMG_ACTIVE;
        end else begin
          cnt <= cnt - 16'h1;
        end
        default: state <= SMG_ACTIVE;
      endcase
    end
  end

  // ****************************************************************
  // Clock enables, hold and conversion start
  // ****************************************************************
  wire logic     asleep = state == SMG_ASLEEP;
  wire logic     run    = state == SMG_ACTIVE;
  smg_clk_s      next_clk;
  always_comb begin
    next_clk = '{default: 1'b1};
    if (asleep) begin
      next_clk.cpu   = 1'b0;
      next_clk.flash = 1'b0;
      if (mode != SEL_IDLE)
        next_clk.io = 1'b0;
      if (mode != SEL_IDLE && mode != SEL_NOISE) begin
        next_clk.adc = 1'b0;
        next_clk.asy = mode == SEL_PSAVE;
        next_clk.osc = mode == SEL_STANDBY;
      end
    end
  end

  // Conversion start only at entry into the quiet modes
  wire logic next_adc = run & go_sleep & adc_enable_i &
    ((sleep_select == SEL_IDLE) | (sleep_select == SEL_NOISE));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_en_o    <= '{default: 1'b1};
      cpu_hold_o  <= 1'b0;
      adc_start_o <= 1'b0;
    end else begin
      clk_en_o    <= next_clk;
      cpu_hold_o  <= ~run & ~(asleep & reset_wake_i);
      adc_start_o <= next_adc;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_halt_no_arm: assert property (
    @(posedge clk_i) disable iff (rst_i)
    run && halt_i && !sleep_arm |=> state == SMG_ACTIVE)
    else $error("halt without arm left active state");

  a_hold_four: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(state == SMG_HOLD) |-> (state == SMG_HOLD) [*4]
    ##1 state == SMG_ACTIVE)
    else $error("wake hold not four cycles");

  a_idle_gates: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asleep && mode == SEL_IDLE |=> !clk_en_o.cpu && clk_en_o.io
    && clk_en_o.adc)
    else $error("idle gating wrong");

  a_noise_gates: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asleep && mode == SEL_NOISE |=> !clk_en_o.io && clk_en_o.adc)
    else $error("noise mode gating wrong");

  a_pdown_osc: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asleep && mode == SEL_PDOWN |=> !clk_en_o.osc && !clk_en_o.asy)
    else $error("power-down left a clock on");

  a_psave_gates: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asleep && mode == SEL_PSAVE |=> clk_en_o.asy && !clk_en_o.io
    && !clk_en_o.osc)
    else $error("power-save gating wrong");

  a_standby_osc: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asleep && mode == SEL_STANDBY |=> clk_en_o.osc && !clk_en_o.asy
    && !clk_en_o.cpu)
    else $error("standby gating wrong");

  a_reserved_sel: assert property (
    @(posedge clk_i) disable iff (rst_i)
    run && halt_i && !sel_legal |=> run)
    else $error("reserved code entered sleep");

  a_noise_wake: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asleep && mode == SEL_NOISE && !async_wake && !t2_wake
    && !quiet_wake && !reset_wake_i |=> asleep)
    else $error("noise mode woke on a foreign source");

  a_pdown_wake: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asleep && (mode == SEL_PDOWN || mode == SEL_STANDBY)
    && !async_wake && !reset_wake_i |=> asleep)
    else $error("power-down woke on a foreign source");

  a_pdown_startup: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asleep && long_up && woken && !reset_wake_i |=>
    state == SMG_STARTUP && cnt == 16'(STARTUP_CYC - 1))
    else $error("power-down wake skipped start-up");

  a_adc_start: assert property (
    @(posedge clk_i) disable iff (rst_i)
    adc_start_o |-> $past(go_sleep) && $past(adc_enable_i))
    else $error("conversion start without entry");

  a_reset_wake: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asleep && reset_wake_i |=> restart_o && run && !cpu_hold_o)
    else $error("reset wake did not restart");

  a_standby_six: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asleep && mode == SEL_STANDBY && woken && !reset_wake_i
    |-> ##11 run)
    else $error("standby wake too slow");

  a_ctrl_upper: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sleep_control[7:4] == 4'h0)
    else $error("control upper bits not zero");

endmodule // smg_sleep_ctrl

//--- smg_pkg.sv
// Shared constants and types for the sleep and clock gating block
package smg_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] ADR_SLEEP_CTRL = 4'h0;
  localparam logic [3:0] ADR_CLK_DIV    = 4'h4;
  localparam logic [3:0] ADR_STATUS     = 4'h8;

  // Sleep control field layout and reset value
  localparam int         SC_ARM_BIT  = 0;
  localparam int         SC_SEL_LO   = 1;
  localparam int         SC_SEL_HI   = 3;
  localparam logic [7:0] SC_RESET    = 8'h00;
  localparam logic [7:0] SC_WR_MASK  = 8'h0f;

  // Divider select: largest legal code, reset value
  localparam logic [3:0] DIV_MAX_SEL = 4'h8;
  localparam logic [3:0] DIV_RESET   = 4'h0;

  // Sleep select encodings
  localparam logic [2:0] SEL_IDLE    = 3'h0;
  localparam logic [2:0] SEL_NOISE   = 3'h1;
  localparam logic [2:0] SEL_PDOWN   = 3'h2;
  localparam logic [2:0] SEL_PSAVE   = 3'h3;
  localparam logic [2:0] SEL_STANDBY = 3'h6;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ          = 50;
  localparam int HOLD_CYC         = 4;
  localparam int STANDBY_WAKE_CYC = 6;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    SMG_ACTIVE,
    SMG_ASLEEP,
    SMG_STARTUP,
    SMG_HOLD
  } smg_state_e;

  // Clock domain enables
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic osc;
  } smg_clk_s;

  // Wake request sources
  typedef struct packed {
    logic line_zero_level;
    logic line_zero_edge;
    logic pin_change;
    logic serial_start;
    logic t2_ovf;
    logic t2_cmp;
    logic store_ready;
    logic adc_done;
    logic other_io;
  } smg_wake_s;

endpackage

//--- smg_core_model.sv
// Core and wake-source model facing the sleep controller
`timescale 1ns/1ps
module smg_core_model
  import smg_pkg::*;
(
  // Clock
  input  wire logic clk_i,
  // Core and wake requests
  output logic      halt_o,
  output logic      reset_wake_o,
  output smg_wake_s wake_o
);
  // Quiet at time zero so nothing wakes by accident
  initial begin
    halt_o       = 1'b0;
    reset_wake_o = 1'b0;
    wake_o       = '0;
  end
  // One-cycle halt pulse, issued right after arming
  task automatic halt();
    @(posedge clk_i);
    halt_o <= 1'b1;
    @(posedge clk_i);
    halt_o <= 1'b0;
  endtask
  // Levels stay up until released, long enough to be seen
  task automatic set_wake(input logic [8:0] v, input logic r);
    @(posedge clk_i);
    wake_o       <= v;
    reset_wake_o <= r;
  endtask
endmodule // smg_core_model

//--- testbench.sv
// Self-checking bench for the sleep and clock gating block
`timescale 1ns/1ps
module testbench;
  import smg_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [3:0]  adr_i = 0, sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, rd;
  logic        ack_o, cpu_hold_o, adc_start_o, restart_o, sys_tick_o;
  logic        halt_i, reset_wake_i, adc_enable_i = 1, irq_enable_i = 1;
  logic [1:0]  t2_mask = 2'h3;
  smg_wake_s   wake_i;
  smg_clk_s    clk_en_o;
  int          fail_count = 0, checks = 0, n, a, b;
  bit          seen;
  logic [2:0]  md [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  logic [5:0]  en [5] = '{6'h0f, 6'h07, 6'h00, 6'h02, 6'h01};
  logic [8:0]  bad [5] = '{9'h000, 9'h001, 9'h010, 9'h004, 9'h002};
  logic [8:0]  good [5] = '{9'h001, 9'h002, 9'h040, 9'h010, 9'h020};
  localparam int SU = 2; // Short oscillator start-up keeps runs brief
  int          up [5] = '{0, 0, SU, SU, STANDBY_WAKE_CYC};

  smg_sleep_ctrl #(.STARTUP_CYC(SU)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .halt_i(halt_i), .reset_wake_i(reset_wake_i),
    .adc_enable_i(adc_enable_i), .irq_enable_i(irq_enable_i),
    .timer_two_irq_mask_i(t2_mask), .wake_i(wake_i),
    .clk_en_o(clk_en_o), .cpu_hold_o(cpu_hold_o),
    .adc_start_o(adc_start_o), .restart_o(restart_o),
    .sys_tick_o(sys_tick_o));
  smg_core_model i_core (.clk_i(clk_i), .halt_o(halt_i),
    .reset_wake_o(reset_wake_i), .wake_o(wake_i));

  // 50 MHz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic wb(input logic w, input logic [3:0] ad,
                    input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, ad, 4'hf, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 50);
    q = dat_o;
    cmp("wb_ack", 1, ack_o);
    {cyc_i, stb_i, we_i} <= 3'b000;
    @(posedge clk_i);
  endtask
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Cycles until the next divided tick, bounded
  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (sys_tick_o !== 1'b1 && c < 600);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ADR_SLEEP_CTRL, 0, rd); cmp("ctrl_reset", 32'h0, rd);
    wb(1, ADR_SLEEP_CTRL, 32'hff, rd);
    wb(0, ADR_SLEEP_CTRL, 0, rd); cmp("ctrl_ro", 32'h0f, rd);
    wb(1, 4'hc, 32'h5, rd);
    wb(0, 4'hc, 0, rd); cmp("unmapped", 32'h0, rd);
    $display("test registers done");
    // Unarmed halt and reserved select must both be ignored
    for (int k = 0; k < 2; k++) begin
      wb(1, ADR_SLEEP_CTRL, k ? 32'hb : 32'h4, rd);
      i_core.halt();
      repeat (4) @(posedge clk_i);
      wb(0, ADR_STATUS, 0, rd); cmp("no_sleep", 0, rd[5:3]);
      cmp("no_gate", 6'h3f, clk_en_o);
    end
    $display("test refused halt done");
    // Every mode: gating, rejected source (none driven in idle), accepted source, hold
    for (int k = 0; k < 5; k++) begin
      wb(1, ADR_SLEEP_CTRL, {28'h0, md[k], 1'b1}, rd);
      seen = 0;
      i_core.halt();
      repeat (3) begin
        @(posedge clk_i);
        if (adc_start_o === 1'b1) seen = 1;
      end
      cmp("conv_start", md[k] < 2, seen);
      cmp("clk_en", en[k],clk_en_o);
      cmp("cpu_hold", 1, cpu_hold_o);
      i_core.set_wake(bad[k], 0);
      repeat (8) @(posedge clk_i);
      wb(0, ADR_STATUS, 0, rd);
      cmp("asleep", {3'h1, md[k]}, rd);
      i_core.set_wake(good[k], 0);
      n = 0;
      while (cpu_hold_o !== 1'b0 && n < 60) begin
        @(posedge clk_i);
        n++;
      end
      // Wake sample (pins two more), start-up, four held, release
      a = (k == 2 ? 3 : 1) + up[k] + HOLD_CYC + 2;
      cmp("hold_len", a, n);
      i_core.set_wake(0, 0);
      wb(0, ADR_STATUS, 0, rd); cmp("awake", 0, rd[5:3]);
      cmp("clk_on", 6'h3f, clk_en_o);
    end
    $display("test sleep modes done");
    // Reset request while powered down restarts from the vector
    wb(1, ADR_SLEEP_CTRL, 32'h5, rd);
    i_core.halt();
    repeat (3) @(posedge clk_i);
    i_core.set_wake(0, 1);
    seen = 0;
    repeat (6) begin
      @(posedge clk_i);
      if (restart_o === 1'b1) seen = 1;
    end
    cmp("restart", 1, seen);
    cmp("rst_hold", 0, cpu_hold_o);
    i_core.set_wake(0, 0);
    $display("test reset wake done");
    // Divider: steady rate, reserved code, slow to fast switch
    wb(1, ADR_CLK_DIV, 32'h2, rd);
    gap(n); gap(n); gap(n); cmp("div4", 4, n);
    wb(1, ADR_CLK_DIV, 32'h9, rd);
    gap(n); gap(n); cmp("div_keep", 4, n);
    wb(1, ADR_CLK_DIV, 32'h3, rd);
    gap(n); gap(n); gap(n); cmp("div8", 8, n);
    wb(1, ADR_CLK_DIV, 32'h1, rd);
    gap(a); gap(b); gap(n);
    cmp("no_fast", 1, a >= 2 && b >= 2 && a <= 8);
    cmp("div2", 2, n);
    $display("test divider done");
    report_and_stop();
  end
endmodule // testbench
